// >>> logic/par_port_pkg.sv
// Constants and types for the strobed parallel request port
// Notes on behaviour
// - Strobe valid only after 3 ms active with no debounce running.
// - After valid strobe, lines must hold stable one sample time; change restarts it.
// - Port values latched when sample time ends, even if strobe already released.
// - Debounce (10 to 2550 ms) starts on strobe release; no new strobe until expired.
// - Strobe activity during debounce only restarts the debounce timer.
// - Debounce setting is kept longer than sample setting, adjusting the other.
// - Message requests need message level, except nine-bit decimal format.
// - Nine-bit decimal: select line is hundreds digit, message 0, data 100.
// - Embedded data taken only at data level; ignored unless collection pending.
// - Message-level strobe aborts data collection; it becomes a new request in one-strobe formats only.
// - Automatic modes sample continuously; new value stable one sample time requests.
// - Automatic detection suspended at data level, resumed at message level.
// - Control polarity setting: negative means message and idle strobe high.
// - Data polarity setting: negative means low line reads as 1.
// - Seven formats; format fixes the number of strobes per request.
// - Four-bit binary: D0-D3, two strobes, high nibble first then low.
// - Eight-bit binary: one strobe, D7 weighs 128 down to D0 1.
// - Input only: strobe, select and eight data inputs.
// - Format, sample and debounce times readable and writable at run time.
package par_port_pkg;
    typedef enum logic [2:0] {
        FMT_BCD4   = 3'h0,
        FMT_BCD8   = 3'h1,
        FMT_BCD9   = 3'h2,
        FMT_BIN4   = 3'h3,
        FMT_BIN8   = 3'h4,
        FMT_AUTO1  = 3'h5,
        FMT_AUTO2  = 3'h6
    } port_fmt_t;

    localparam logic [2:0]  STROBE_MIN_MS   = 3'h3;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          TICK_CYCLES     = CLK_HZ / 1000;
    localparam logic [7:0]  RST_SAMPLE_MS   = 8'h0a;
    localparam logic [7:0]  RST_DEBOUNCE_10 = 8'h05;
    localparam logic [2:0]  RST_FMT         = 3'h4;
    localparam logic [7:0]  SAMPLE_MIN      = 8'h01;
    localparam logic [7:0]  DEBOUNCE_MIN    = 8'h01;
    localparam logic [7:0]  HUNDRED         = 8'h64;
endpackage

// >>> logic/par_port.sv
// Strobed parallel request port with automatic change requests
module par_port #(
    parameter int TICK_DIV = par_port_pkg::TICK_CYCLES
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_strobe,
    input  wire logic                 i_msg_sel,
    input  wire logic [7:0]           i_data,
    input  wire logic                 i_ctrl_neg,
    input  wire logic                 i_data_neg,
    input  wire logic                 i_cfg_wr,
    input  wire logic [2:0]           i_cfg_fmt,
    input  wire logic [7:0]           i_cfg_sample_ms,
    input  wire logic [7:0]           i_cfg_debounce_10ms,
    input  wire logic                 i_collect_pending,
    output logic      [2:0]           o_cfg_fmt,
    output logic      [7:0]           o_cfg_sample_ms,
    output logic      [7:0]           o_cfg_debounce_10ms,
    output logic                      o_req_valid,
    output logic      [7:0]           o_req_msg,
    output logic                      o_auto_valid,
    output logic      [7:0]           o_auto_value,
    output logic                      o_auto_prev_valid,
    output logic      [7:0]           o_auto_prev,
    output logic                      o_data_valid,
    output logic      [7:0]           o_data_byte,
    output logic                      o_abort,
    output logic                      o_debouncing
);
    import par_port_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_WIDTH, S_SAMPLE, S_WAIT_REL, S_DEBOUNCE} st_t;

    // Inputs double-synchronised; stage one feeds stage two only
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= {i_strobe, i_msg_sel, i_data};
            sync2_q <= sync1_q;
        end
    end

    // Polarity mapping of control and data lines
    wire       strobe_act = sync2_q[9] ^ i_ctrl_neg;
    wire       is_msg     = sync2_q[8] ~^ i_ctrl_neg;
    wire [7:0] data_val   = sync2_q[7:0] ^ {8{i_data_neg}};
    wire [8:0] port_val   = {is_msg, data_val};

    // Millisecond tick
    logic [13:0] pre_q;
    logic        tick_q;
    // A shorter tick divider only speeds up simulation; the default gives real milliseconds
    wire         pre_end = (pre_q == 14'(TICK_DIV - 1));
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pre_q  <= 14'h0000;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_end ? 14'h0000 : pre_q + 14'h0001;
            tick_q <= pre_end;
        end
    end

    // Run-time configuration; debounce kept longer than sample
    logic [2:0] fmt_q;
    logic [7:0] smp_q;
    logic [7:0] dbn_q;
    wire  [11:0] dbn_ms_new = 12'(i_cfg_debounce_10ms) * 12'h00a;
    wire  [7:0] smp_in  = (i_cfg_sample_ms == 8'h00) ? SAMPLE_MIN : i_cfg_sample_ms;
    wire  [7:0] dbn_in  = (i_cfg_debounce_10ms == 8'h00) ? DEBOUNCE_MIN : i_cfg_debounce_10ms;
    wire  [7:0] dbn_fix = 8'(({4'h0, smp_in} / 12'h00a) + 12'h001);
    wire        smp_chg = i_cfg_sample_ms != smp_q;
    wire  [11:0] dbn_in_ms = 12'(dbn_in) * 12'h00a;
    wire  [7:0] smp_fix = (dbn_in_ms > 12'h0ff) ? i_cfg_sample_ms : 8'(dbn_in_ms - 12'h001);
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            fmt_q <= RST_FMT;
            smp_q <= RST_SAMPLE_MS;
            dbn_q <= RST_DEBOUNCE_10;
        end else if (i_cfg_wr) begin
            fmt_q <= i_cfg_fmt;
            if (smp_chg) begin
                smp_q <= smp_in;
                dbn_q <= (dbn_ms_new > {4'h0, smp_in}) ? dbn_in : dbn_fix;
            end else begin
                dbn_q <= dbn_in;
                smp_q <= (dbn_in_ms > {4'h0, smp_q}) ? smp_q : smp_fix;
            end
        end
    end

    // Shared millisecond counter for width, sample and debounce intervals
    st_t         st_q;
    logic [11:0] ms_q;
    logic [8:0]  snap_q;
    logic [1:0]  cnt_q;
    logic [7:0]  part_q;
    logic        was_act_q;
    wire [11:0]  dbn_ms   = 12'(dbn_q) * 12'h00a;
    wire         is_auto  = (fmt_q == FMT_AUTO1) || (fmt_q == FMT_AUTO2);
    wire         changed  = port_val != snap_q;
    wire         smp_done = tick_q && (ms_q + 12'h001 >= {4'h0, smp_q});

    // Decode of a latched value
    wire [3:0]  lo_n  = snap_q[3:0];
    wire [3:0]  hi_n  = snap_q[7:4];
    // Widen before the product so the tens digit is not cut to four bits
    wire [7:0]  bcd2  = (8'(hi_n) * 8'h0a) + 8'(lo_n);
    wire [1:0]  need  = (fmt_q == FMT_BCD4) ? 2'h3 :
                        ((fmt_q == FMT_BCD8) || (fmt_q == FMT_BIN4)) ? 2'h2 : 2'h1;
    wire        last  = (cnt_q + 2'h1) == need;
    wire [7:0]  bcd_acc  = 8'(part_q * 8'h0a) + 8'(lo_n);
    wire [7:0]  msg_val  =
        (fmt_q == FMT_BIN8) ? snap_q[7:0] :
        (fmt_q == FMT_BIN4) ? {part_q[3:0], lo_n} :
        (fmt_q == FMT_BCD9) ? (snap_q[8] ? bcd2 : bcd2 + HUNDRED) :
        (fmt_q == FMT_BCD8) ? 8'(part_q * 8'h64) + bcd2 :
        bcd_acc;
    wire [7:0]  part_nx  = (fmt_q == FMT_BIN4) ? {4'h0, lo_n} :
                           (fmt_q == FMT_BCD8) ? {4'h0, lo_n} : bcd_acc;
    wire        msg_ok   = snap_q[8] || (fmt_q == FMT_BCD9);
    wire        auto_go  = is_auto && is_msg;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q              <= S_IDLE;
            ms_q              <= 12'h000;
            snap_q            <= 9'h000;
            cnt_q             <= 2'h0;
            part_q            <= 8'h00;
            was_act_q         <= 1'b0;
            o_req_valid       <= 1'b0;
            o_req_msg         <= 8'h00;
            o_auto_valid      <= 1'b0;
            o_auto_value      <= 8'h00;
            o_auto_prev_valid <= 1'b0;
            o_auto_prev       <= 8'h00;
            o_data_valid      <= 1'b0;
            o_data_byte       <= 8'h00;
            o_abort           <= 1'b0;
        end else begin
            o_req_valid  <= 1'b0;
            o_auto_valid <= 1'b0;
            o_data_valid <= 1'b0;
            o_abort      <= 1'b0;
            if (is_auto) begin
                cnt_q  <= 2'h0;
                part_q <= 8'h00;
                if (!auto_go) begin
                    st_q   <= S_IDLE;
                    ms_q   <= 12'h000;
                    snap_q <= port_val;
                end else if (changed) begin
                    snap_q <= port_val;
                    ms_q   <= 12'h000;
                    st_q   <= S_SAMPLE;
                end else if (st_q == S_SAMPLE) begin
                    if (tick_q) begin
                        ms_q <= ms_q + 12'h001;
                    end
                    if (smp_done) begin
                        st_q              <= S_IDLE;
                        o_auto_valid      <= 1'b1;
                        o_auto_value      <= snap_q[7:0];
                        o_auto_prev_valid <= was_act_q;
                        o_auto_prev       <= o_auto_value;
                        was_act_q         <= 1'b1;
                    end
                end else begin
                    st_q <= S_IDLE;
                end
            end else begin
                case (st_q)
                    S_IDLE: begin
                        ms_q <= 12'h000;
                        if (strobe_act) begin
                            st_q <= S_WIDTH;
                        end
                    end
                    S_WIDTH: begin
                        if (!strobe_act) begin
                            st_q <= S_IDLE;
                        end else if (tick_q) begin
                            ms_q <= ms_q + 12'h001;
                            if (ms_q + 12'h001 >= 12'(STROBE_MIN_MS) + 12'h001) begin
                                st_q   <= S_SAMPLE;
                                ms_q   <= 12'h000;
                                snap_q <= port_val;
                            end
                        end
                    end
                    S_SAMPLE: begin
                        if (changed) begin
                            snap_q <= port_val;
                            ms_q   <= 12'h000;
                        end else begin
                            if (tick_q) begin
                                ms_q <= ms_q + 12'h001;
                            end
                            if (smp_done) begin
                                st_q <= S_WAIT_REL;
                                ms_q <= 12'h000;
                                if (snap_q[8] && i_collect_pending) begin
                                    o_abort <= 1'b1;
                                end
                                if (!snap_q[8] && (fmt_q != FMT_BCD9)) begin
                                    if (i_collect_pending) begin
                                        o_data_valid <= 1'b1;
                                        o_data_byte  <= snap_q[7:0];
                                    end
                                end else if (msg_ok) begin
                                    if (snap_q[8] && i_collect_pending) begin
                                        cnt_q  <= 2'h0;
                                        part_q <= 8'h00;
                                    end
                                    if (last || (snap_q[8] && i_collect_pending && need == 2'h1)) begin
                                        o_req_valid <= 1'b1;
                                        o_req_msg   <= msg_val;
                                        cnt_q       <= 2'h0;
                                        part_q      <= 8'h00;
                                    end else if (!(snap_q[8] && i_collect_pending)) begin
                                        cnt_q  <= cnt_q + 2'h1;
                                        part_q <= part_nx;
                                    end
                                end
                            end
                        end
                    end
                    S_WAIT_REL: begin
                        ms_q <= 12'h000;
                        if (!strobe_act) begin
                            st_q <= S_DEBOUNCE;
                        end
                    end
                    S_DEBOUNCE: begin
                        if (strobe_act) begin
                            ms_q <= 12'h000;
                        end else if (tick_q) begin
                            ms_q <= ms_q + 12'h001;
                            if (ms_q + 12'h001 >= dbn_ms) begin
                                st_q <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Status outputs from flip-flops
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_cfg_fmt           <= RST_FMT;
            o_cfg_sample_ms     <= RST_SAMPLE_MS;
            o_cfg_debounce_10ms <= RST_DEBOUNCE_10;
            o_debouncing        <= 1'b0;
        end else begin
            o_cfg_fmt           <= fmt_q;
            o_cfg_sample_ms     <= smp_q;
            o_cfg_debounce_10ms <= dbn_q;
            o_debouncing        <= (st_q == S_DEBOUNCE);
        end
    end
endmodule

// >>> dv/ext_ctrl_model.sv
// Behavioural model of the controller that drives the port pins
module ext_ctrl_model (
    input  wire logic       i_ctrl_neg,
    input  wire logic       i_data_neg,
    input  wire logic       i_strobe_on,
    input  wire logic       i_msg_level,
    input  wire logic [7:0] i_value,
    output logic            o_strobe,
    output logic            o_msg_sel,
    output logic      [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins hold until the bench changes the request, so lines stay stable through sampling
    assign o_strobe  = i_strobe_on ^ i_ctrl_neg;
    assign o_msg_sel = ~(i_msg_level ^ i_ctrl_neg);
    assign o_data    = i_data_neg ? ~i_value : i_value;
endmodule

// >>> dv/par_port_props.sv
// Assertion checker for the strobed parallel request port
module par_port_props
    import par_port_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_strobe,
    input wire logic       i_msg_sel,
    input wire logic       i_ctrl_neg,
    input wire logic       i_cfg_wr,
    input wire logic [2:0] i_cfg_fmt,
    input wire logic [7:0] i_cfg_sample_ms,
    input wire logic [2:0] o_cfg_fmt,
    input wire logic [7:0] o_cfg_sample_ms,
    input wire logic [7:0] o_cfg_debounce_10ms,
    input wire logic       o_req_valid,
    input wire logic       o_auto_valid,
    input wire logic       o_data_valid,
    input wire logic       o_debouncing
);
    timeunit 1ns;
    timeprecision 1ns;
    wire         strobe_act = i_strobe ^ i_ctrl_neg;
    wire         msg_lvl    = (i_msg_sel == i_ctrl_neg);
    logic [16:0] idle_q;
    logic [3:0]  dat_q;
    logic [3:0]  msg_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // Run lengths of raw pin levels; the margin of 8 covers the synchroniser delay
    always_ff @(posedge i_core_clk) begin
        idle_q <= (i_sys_rst || strobe_act) ? 17'h0 : idle_q + {16'h0, ~&idle_q};
        dat_q  <= (i_sys_rst || msg_lvl) ? 4'h0 : dat_q + {3'h0, ~&dat_q};
        msg_q  <= (i_sys_rst || !msg_lvl) ? 4'h0 : msg_q + {3'h0, ~&msg_q};
    end
    chk_req_pulse: assert property (o_req_valid |=> !o_req_valid)
        else $error("request pulse too long");
    chk_fmt_readback: assert property ((i_cfg_wr && i_cfg_fmt != 3'h7) ##1 !i_cfg_wr [*2]
        |=> o_cfg_fmt == $past(i_cfg_fmt, 3)) else $error("format readback wrong");
    chk_sample_readback: assert property ((i_cfg_wr && i_cfg_sample_ms != 8'h00
        && i_cfg_sample_ms != o_cfg_sample_ms) ##1 !i_cfg_wr [*2]
        |=> o_cfg_sample_ms == $past(i_cfg_sample_ms, 3)) else $error("sample readback wrong");
    chk_debounce_longer: assert property ((12'(o_cfg_debounce_10ms) * 12'h00a) > {4'h0, o_cfg_sample_ms})
        else $error("debounce not longer than sample");
    chk_debounce_quiet: assert property ($fell(o_debouncing)
        |-> int'(idle_q) >= (int'(o_cfg_debounce_10ms) * 10 - 1) * TICK_DIV) else $error("debounce ended too soon");
    chk_req_msg_level: assert property ((o_req_valid && o_cfg_fmt != FMT_BCD9) |-> dat_q < 4'h8)
        else $error("request at data level");
    chk_data_level: assert property (o_data_valid |-> msg_q < 4'h8)
        else $error("data byte at message level");
    chk_auto_suspend: assert property (o_auto_valid |-> dat_q < 4'h8)
        else $error("automatic request at data level");
endmodule

bind par_port par_port_props #(.TICK_DIV(TICK_DIV)) u_par_port_props (.i_core_clk, .i_sys_rst, .i_strobe,
    .i_msg_sel, .i_ctrl_neg,
    .i_cfg_wr, .i_cfg_fmt, .i_cfg_sample_ms, .o_cfg_fmt, .o_cfg_sample_ms, .o_cfg_debounce_10ms,
    .o_req_valid, .o_auto_valid, .o_data_valid, .o_debouncing);

// >>> dv/tb_par_port.sv
// Self-checking testbench for the strobed parallel request port
module tb_par_port;
    timeunit 1ns;
    timeprecision 1ns;
    import par_port_pkg::*;
    logic       clk = 1'b0;
    logic       rst, str_on, msg_lvl, c_neg, d_neg, cfg_wr, collect;
    // Short millisecond tick keeps the run small; only the waits in pulse scale with it, the other tasks wait fixed cycle counts
    localparam int TB_TICK = 20;
    logic       pin_str, pin_sel, req_v, auto_v, deb_on, data_v, abort_v, prev_v;
    logic [2:0] cfg_fmt, fmt_rb;
    logic [7:0] cfg_smp, cfg_deb, value, pin_data, smp_rb, deb_rb, req_msg, auto_val, data_byte, prev_val;
    int         bad_count = 0, total_checks = 0, req_cnt = 0, auto_cnt = 0, data_cnt = 0, abort_cnt = 0, n;

    always #50 clk = ~clk;
    // Pulses are counted on the falling edge, clear of the launching edge
    always @(negedge clk) begin
        if (req_v === 1'b1) req_cnt++;
        if (auto_v === 1'b1) auto_cnt++;
        if (data_v === 1'b1) data_cnt++;
        if (abort_v === 1'b1) abort_cnt++;
    end

    ext_ctrl_model u_ext_ctrl_model (.i_ctrl_neg(c_neg), .i_data_neg(d_neg), .i_strobe_on(str_on),
        .i_msg_level(msg_lvl), .i_value(value), .o_strobe(pin_str), .o_msg_sel(pin_sel), .o_data(pin_data));
    par_port #(.TICK_DIV(TB_TICK)) u_par_port (.i_core_clk(clk), .i_sys_rst(rst), .i_strobe(pin_str),
        .i_msg_sel(pin_sel),
        .i_data(pin_data), .i_ctrl_neg(c_neg), .i_data_neg(d_neg), .i_cfg_wr(cfg_wr), .i_cfg_fmt(cfg_fmt),
        .i_cfg_sample_ms(cfg_smp), .i_cfg_debounce_10ms(cfg_deb), .i_collect_pending(collect),
        .o_cfg_fmt(fmt_rb), .o_cfg_sample_ms(smp_rb), .o_cfg_debounce_10ms(deb_rb), .o_req_valid(req_v),
        .o_req_msg(req_msg), .o_auto_valid(auto_v), .o_auto_value(auto_val), .o_auto_prev_valid(prev_v),
        .o_auto_prev(prev_val), .o_data_valid(data_v), .o_data_byte(data_byte), .o_abort(abort_v),
        .o_debouncing(deb_on));

    task automatic close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic bit hit(input int sel, input int want);
        return sel == 0 ? req_cnt >= want : sel == 1 ? auto_cnt >= want : deb_on === 1'b0;
    endfunction

    // Bounded wait; n returns the cycles spent
    task automatic wait_for(input int sel, input int want, input int lim);
        n = 0;
        while (!hit(sel, want) && n < lim) begin
            step(1);
            n++;
        end
        if (n >= lim) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic cfg(input logic [2:0] f, input logic [7:0] s, input logic [7:0] d);
        cfg_fmt = f;
        cfg_smp = s;
        cfg_deb = d;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        step(3);
    endtask

    // One strobed transfer: strobe held past width and sample, then the debounce waited out
    task automatic pulse(input logic [7:0] v, input logic lvl);
        value = v;
        msg_lvl = lvl;
        str_on = 1'b1;
        step(6 * TB_TICK);
        str_on = 1'b0;
        step(14 * TB_TICK);
    endtask

    task automatic t_config;
        cfg(FMT_BIN8, 8'h01, 8'h01);
        check({5'h0, fmt_rb}, {5'h0, FMT_BIN8});
        check(smp_rb, 8'h01);
        check(deb_rb, 8'h01);
        cfg(FMT_BIN8, 8'h32, 8'h01);
        check(smp_rb, 8'h32);
        check({7'h0, deb_rb >= 8'h06}, 8'h01);
        cfg(FMT_BIN8, 8'h32, 8'h02);
        check(deb_rb, 8'h02);
        check({7'h0, smp_rb < 8'h14}, 8'h01);
        cfg(FMT_BIN8, 8'h01, 8'h01);
    endtask

    // Strobe is released before the sample time can end, so the latch must not need it held
    task automatic t_bin8;
        value = 8'ha5;
        str_on = 1'b1;
        step(58);
        check(req_cnt[7:0], 8'h00);
        step(32);
        str_on = 1'b0;
        wait_for(0, 1, 60);
        check(req_msg, 8'ha5);
        step(5);
        check({7'h0, deb_on}, 8'h01);
        step(100);
        str_on = 1'b1;
        step(10);
        str_on = 1'b0;
        wait_for(2, 0, 240);
        check({7'h0, n >= 180}, 8'h01);
        check(req_cnt[7:0], 8'h01);
    endtask

    task automatic t_bin4;
        int r;
        cfg(FMT_BIN4, 8'h01, 8'h01);
        r = req_cnt;
        pulse(8'hfb, 1'b1);
        check(req_cnt[7:0] - r[7:0], 8'h00);
        pulse(8'h07, 1'b1);
        check(req_cnt[7:0] - r[7:0], 8'h01);
        check(req_msg, 8'hb7);
    endtask

    task automatic t_bcd9;
        cfg(FMT_BCD9, 8'h01, 8'h01);
        pulse(8'h42, 1'b0);
        check(req_msg, 8'h8e);
        pulse(8'h42, 1'b1);
        check(req_msg, 8'h2a);
    endtask

    task automatic t_data;
        int r;
        cfg(FMT_BIN8, 8'h01, 8'h01);
        r = req_cnt;
        pulse(8'h5e, 1'b0);
        check(req_cnt[7:0] - r[7:0], 8'h00);
        check(data_cnt[7:0], 8'h00);
        collect = 1'b1;
        pulse(8'h5e, 1'b0);
        check(data_cnt[7:0], 8'h01);
        check(data_byte, 8'h5e);
        pulse(8'h21, 1'b1);
        check(abort_cnt[7:0], 8'h01);
        check(req_msg, 8'h21);
        check(req_cnt[7:0] - r[7:0], 8'h01);
        collect = 1'b0;
        pulse(8'h33, 1'b1);
        check(abort_cnt[7:0], 8'h01);
        check(req_msg, 8'h33);
    endtask

    task automatic t_auto;
        int a;
        cfg(FMT_AUTO2, 8'h01, 8'h01);
        c_neg = 1'b0;
        d_neg = 1'b0;
        step(40);
        a = auto_cnt;
        value = 8'h3c;
        wait_for(1, a + 1, 60);
        check(auto_val, 8'h3c);
        msg_lvl = 1'b0;
        value = 8'hc3;
        step(60);
        check(auto_cnt[7:0] - a[7:0], 8'h01);
        msg_lvl = 1'b1;
        wait_for(1, a + 2, 60);
        check(auto_val, 8'hc3);
        check(prev_val, 8'h3c);
        check({7'h0, prev_v}, 8'h01);
    endtask

    initial begin
        rst = 1'b1;
        {str_on, cfg_wr, collect} = 3'h0;
        {msg_lvl, c_neg, d_neg} = 3'h7;
        cfg_fmt = 3'h4;
        {cfg_smp, cfg_deb, value} = {8'h0a, 8'h05, 8'h00};
        step(6);
        rst = 1'b0;
        step(3);
        t_config();
        t_bin8();
        t_auto();
        t_bin4();
        t_bcd9();
        t_data();
        close_out();
    end
endmodule
